// ---- design/phcr_cfg.svh ----
// Offsets, field positions, fixed values and reset values of the configuration header registers.
`ifndef PHCR_CFG_SVH
`define PHCR_CFG_SVH

// ----------------------------------------------------------------------------
// Configuration double-word and byte offsets
// ----------------------------------------------------------------------------
`define PHCR_OFS_HDR_DW 8'h0C
`define PHCR_OFS_HDR_BYTE 8'h0E
`define PHCR_OFS_CTRL_BASE 8'h10
`define PHCR_OFS_VEXT_BASE 8'h14
`define PHCR_OFS_CARD_BASE 8'h18
`define PHCR_OFS_CARD_PTR 8'h28
`define PHCR_OFS_SUBSYS 8'h2C
`define PHCR_OFS_CAP_PTR 8'h34
`define PHCR_OFS_PM_CAP 8'h44
`define PHCR_OFS_PM_CTRL 8'h48

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define PHCR_ADDR_W 8
`define PHCR_DATA_W 32
`define PHCR_BE_W 4
`define PHCR_DW_LSB 2
`define PHCR_CTRL_LSB 11
`define PHCR_CTRL_W 21
`define PHCR_VEXT_LSB 14
`define PHCR_VEXT_W 18
`define PHCR_HDR_LSB 16
`define PHCR_BIST_LSB 24
`define PHCR_SSDEV_LSB 16
`define PHCR_SSVEN_LSB 0
`define PHCR_ID_W 16
`define PHCR_SINGLE_FN_BIT 23

// ----------------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------------
`define PHCR_BIST_VAL 8'h00
`define PHCR_HDR_TYPE_VAL 8'h00
`define PHCR_CAP_PTR_VAL 8'h44
`define PHCR_ZERO_WORD 32'h0000_0000
`define PHCR_CTRL_SIZE_PAT 32'hFFFF_F800
`define PHCR_VEXT_SIZE_PAT 32'hFFFF_C000
`define PHCR_ALL_ONES 32'hFFFF_FFFF
`define PHCR_BE_ALL 4'hF
`define PHCR_SUBSYS_RST 32'h0000_0000

`endif

// ---- design/phcr_pkg.sv ----
// Types shared by the configuration header register modules.
`include "phcr_cfg.svh"

package phcr_pkg;

    // Which register of the header a configuration access hits.
    typedef enum logic [2:0] {
        PHCR_SEL_NONE = 3'b000,
        PHCR_SEL_HDR = 3'b001,
        PHCR_SEL_CTRL = 3'b010,
        PHCR_SEL_VEXT = 3'b011,
        PHCR_SEL_CARD = 3'b100,
        PHCR_SEL_SUBSYS = 3'b101,
        PHCR_SEL_CAPP = 3'b110
    } phcr_sel_e;

    typedef logic [`PHCR_ADDR_W-1:0] phcr_addr_t;
    typedef logic [`PHCR_DATA_W-1:0] phcr_word_t;
    typedef logic [`PHCR_BE_W-1:0] phcr_be_t;

    typedef struct packed {
        logic [`PHCR_CTRL_W-1:0] ctrl_upper;
        logic [`PHCR_VEXT_W-1:0] vext_upper;
        phcr_word_t rdata;
        logic rvalid;
        phcr_sel_e rd_sel;
        logic function_reset_in_meta;
        logic function_reset_in_sync;
    } phcr_state_s;

    typedef struct packed {
        phcr_word_t ident;
    } phcr_subsys_state_s;

endpackage

// ---- design/phcr_ssid_if.sv ----
// Signals between the header register bank and its subsystem identity holder.
`timescale 1ns/1ps

interface phcr_ssid_if;
    import phcr_pkg::*;
    logic eeprom_load;
    phcr_word_t eeprom_data;
    logic access_wr;
    phcr_word_t access_data;
    logic func_reset;
    phcr_word_t ident;

    modport keeper (
        input eeprom_load,
        input eeprom_data,
        input access_wr,
        input access_data,
        input func_reset,
        output ident
    );

    modport user (
        output eeprom_load,
        output eeprom_data,
        output access_wr,
        output access_data,
        output func_reset,
        input ident
    );
endinterface

// ---- design/phcr_subsys_id.sv ----
// Holder of the subsystem device and vendor identifiers.
`timescale 1ns/1ps
`include "phcr_cfg.svh"

module phcr_subsys_id (
    // Clock and fundamental reset
    input wire logic clk,
    input wire logic rstn,
    // Load sources and identity out
    phcr_ssid_if.keeper ssid
);
    import phcr_pkg::*;

    phcr_subsys_state_s st_reg;
    phcr_subsys_state_s st_next;

    // The access register is written after the serial load has run, so it wins a tie.
    always_comb begin
        st_next = st_reg;
        if (ssid.access_wr) begin
            st_next.ident = ssid.access_data;
        end else if (ssid.eeprom_load) begin
            st_next.ident = ssid.eeprom_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || ssid.func_reset) begin
            st_reg <= `PHCR_SUBSYS_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ssid.ident = st_reg.ident;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_subsys_clear;
        @(posedge clk) ssid.func_reset |=> (ssid.ident == `PHCR_SUBSYS_RST);
    endproperty
    a_subsys_clear: assert property (p_subsys_clear)
        else $error("Subsystem identity not cleared by function reset.");

    property p_subsys_hold;
        @(posedge clk) disable iff (!rstn)
            (!ssid.access_wr && !ssid.eeprom_load && !ssid.func_reset) |=> $stable(ssid.ident);
    endproperty
    a_subsys_hold: assert property (p_subsys_hold)
        else $error("Subsystem identity changed without a load.");

endmodule // phcr_subsys_id

// ---- design/phcr_header_regs.sv ----
// Configuration header register bank from offset 0Eh to 34h.
`timescale 1ns/1ps
`include "phcr_cfg.svh"

// Contract
// - Self-test byte, bits 15-8 of the header-type half, always reads 00h.
// - Header-type byte reads 00h, a standard type-0 header.
// - Bit 7 of the header-type byte reads 0, single-function device.
// - Controller base reads FFFF F800h after all ones written, a 2 KB window.
// - Controller base bits 31-11 are writable and reset to zero.
// - Controller base bits 10-4 always read zero.
// - Controller base bits 3-0 read zero: 32-bit non-prefetchable memory.
// - Vendor-extension base reads FFFF C000h after all ones written, 16 KB window.
// - Vendor-extension base bits 31-14 are writable and reset to zero.
// - Vendor-extension base bits 13-4 always read zero.
// - Vendor-extension base bits 3-0 read zero: 32-bit non-prefetchable memory.
// - Card-information base and pointer registers always read all zeros.
// - Subsystem identity ignores configuration writes; loads from EEPROM or access register.
// - Subsystem device identifier in bits 31-16, vendor identifier in 15-0.
// - Subsystem identifiers cleared only by fundamental or function reset.
// - Capability pointer byte is read-only and returns 44h.
// - Power-management registers sit at double words 44h and 48h.
module phcr_header_regs (
    // Clock and fundamental reset
    input wire logic clk,
    input wire logic rstn,
    // Configuration access
    input wire phcr_pkg::phcr_addr_t cfg_addr,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire phcr_pkg::phcr_be_t cfg_be,
    input wire phcr_pkg::phcr_word_t cfg_wdata,
    output phcr_pkg::phcr_word_t cfg_rdata,
    output logic cfg_rvalid,
    // Subsystem identity sources
    input wire logic eeprom_id_load,
    input wire phcr_pkg::phcr_word_t eeprom_id_data,
    input wire logic subsys_access_wr,
    input wire phcr_pkg::phcr_word_t subsys_access_data,
    // Function reset pin
    input wire logic function_reset_in,
    // Programmed windows for the memory decoders, and the subsystem identity
    output phcr_pkg::phcr_word_t controller_base_addr,
    output phcr_pkg::phcr_word_t vendor_ext_base_addr,
    output phcr_pkg::phcr_word_t subsys_identity
);
    import phcr_pkg::*;

    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    // The two low address bits are ignored: every access is one double word.
    function automatic phcr_sel_e phcr_decode(input phcr_addr_t addr);
        phcr_addr_t dw;
        dw = {addr[`PHCR_ADDR_W-1:`PHCR_DW_LSB], 2'b00};
        case (dw)
            `PHCR_OFS_HDR_DW: phcr_decode = PHCR_SEL_HDR;
            `PHCR_OFS_CTRL_BASE: phcr_decode = PHCR_SEL_CTRL;
            `PHCR_OFS_VEXT_BASE: phcr_decode = PHCR_SEL_VEXT;
            `PHCR_OFS_CARD_BASE: phcr_decode = PHCR_SEL_CARD;
            `PHCR_OFS_CARD_PTR: phcr_decode = PHCR_SEL_CARD;
            `PHCR_OFS_SUBSYS: phcr_decode = PHCR_SEL_SUBSYS;
            `PHCR_OFS_CAP_PTR: phcr_decode = PHCR_SEL_CAPP;
            default: phcr_decode = PHCR_SEL_NONE;
        endcase
    endfunction

    // Byte-lane merge shared by both base address registers.
    function automatic phcr_word_t phcr_merge(input phcr_word_t old, input phcr_word_t wd, input phcr_be_t be);
        phcr_word_t res;
        res = old;
        for (int i = 0; i < `PHCR_BE_W; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        phcr_merge = res;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    phcr_state_s st_reg;
    phcr_state_s st_next;
    phcr_ssid_if ssid ();
    phcr_word_t ctrl_word;
    phcr_word_t vext_word;
    phcr_word_t hdr_word;
    phcr_word_t capp_word;
    phcr_sel_e wr_sel;
    phcr_sel_e rd_sel_now;

    // Low size and type bits are constant zero, so sizing software sees the window.
    assign ctrl_word = {st_reg.ctrl_upper, {`PHCR_CTRL_LSB{1'b0}}};
    assign vext_word = {st_reg.vext_upper, {`PHCR_VEXT_LSB{1'b0}}};
    // Header byte 0Eh sits in the upper half of double word 0Ch; the lower half is outside this bank.
    assign hdr_word = {`PHCR_BIST_VAL, `PHCR_HDR_TYPE_VAL, 16'h0000};
    // The pointer names the power-management block at 44h, followed by 48h.
    assign capp_word = {24'h00_0000, `PHCR_CAP_PTR_VAL};
    assign wr_sel = phcr_decode(cfg_addr);
    assign rd_sel_now = phcr_decode(cfg_addr);

    // ------------------------------------------------------------------------
    // Subsystem identity holder
    // ------------------------------------------------------------------------
    assign ssid.eeprom_load = eeprom_id_load;
    assign ssid.eeprom_data = eeprom_id_data;
    assign ssid.access_wr = subsys_access_wr;
    assign ssid.access_data = subsys_access_data;
    assign ssid.func_reset = st_reg.function_reset_in_sync;

    phcr_subsys_id u_subsys_id (
        .clk(clk),
        .rstn(rstn),
        .ssid(ssid.keeper)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        phcr_word_t merged;
        merged = `PHCR_ZERO_WORD;
        st_next = st_reg;
        // The reset pin is asynchronous to clk; only the second stage is used.
        st_next.function_reset_in_meta = function_reset_in;
        st_next.function_reset_in_sync = st_reg.function_reset_in_meta;
        st_next.rvalid = cfg_rd;
        if (cfg_rd) begin
            st_next.rd_sel = rd_sel_now;
            case (rd_sel_now)
                PHCR_SEL_HDR: st_next.rdata = hdr_word;
                PHCR_SEL_CTRL: st_next.rdata = ctrl_word;
                PHCR_SEL_VEXT: st_next.rdata = vext_word;
                PHCR_SEL_CARD: st_next.rdata = `PHCR_ZERO_WORD;
                PHCR_SEL_SUBSYS: st_next.rdata = ssid.ident;
                PHCR_SEL_CAPP: st_next.rdata = capp_word;
                default: st_next.rdata = `PHCR_ZERO_WORD;
            endcase
        end
        // Writes to any other register are taken and dropped.
        if (cfg_wr) begin
            case (wr_sel)
                PHCR_SEL_CTRL: begin
                    merged = phcr_merge(ctrl_word, cfg_wdata, cfg_be);
                    st_next.ctrl_upper = merged[`PHCR_DATA_W-1:`PHCR_CTRL_LSB];
                end
                PHCR_SEL_VEXT: begin
                    merged = phcr_merge(vext_word, cfg_wdata, cfg_be);
                    st_next.vext_upper = merged[`PHCR_DATA_W-1:`PHCR_VEXT_LSB];
                end
                default: begin
                    merged = `PHCR_ZERO_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign cfg_rdata = st_reg.rdata;
    assign cfg_rvalid = st_reg.rvalid;
    assign controller_base_addr = ctrl_word;
    assign vendor_ext_base_addr = vext_word;
    assign subsys_identity = ssid.ident;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_ctrl_fill;
        cfg_wr && wr_sel == PHCR_SEL_CTRL && cfg_be == `PHCR_BE_ALL && cfg_wdata == `PHCR_ALL_ONES;
    endsequence

    sequence s_vext_fill;
        cfg_wr && wr_sel == PHCR_SEL_VEXT && cfg_be == `PHCR_BE_ALL && cfg_wdata == `PHCR_ALL_ONES;
    endsequence

    sequence s_read_of(phcr_sel_e sel);
        cfg_rd && !cfg_wr && rd_sel_now == sel;
    endsequence

    property p_selftest_zero;
        @(posedge clk) disable iff (!rstn)
            (cfg_rvalid && st_reg.rd_sel == PHCR_SEL_HDR) |-> cfg_rdata[`PHCR_DATA_W-1:`PHCR_BIST_LSB] == `PHCR_BIST_VAL;
    endproperty
    a_selftest_zero: assert property (p_selftest_zero)
        else $error("Self-test byte read back non-zero.");

    property p_header_type;
        @(posedge clk) disable iff (!rstn)
            (cfg_rvalid && st_reg.rd_sel == PHCR_SEL_HDR) |->
                cfg_rdata[`PHCR_BIST_LSB-1:`PHCR_HDR_LSB] == `PHCR_HDR_TYPE_VAL;
    endproperty
    a_header_type: assert property (p_header_type)
        else $error("Header-type byte read back non-zero.");

    property p_single_fn;
        @(posedge clk) disable iff (!rstn)
            (cfg_rvalid && st_reg.rd_sel == PHCR_SEL_HDR) |-> !cfg_rdata[`PHCR_SINGLE_FN_BIT];
    endproperty
    a_single_fn: assert property (p_single_fn)
        else $error("Multi-function bit read back set.");

    property p_ctrl_sizing;
        @(posedge clk) disable iff (!rstn)
            s_ctrl_fill ##1 s_read_of(PHCR_SEL_CTRL) |=> cfg_rvalid && cfg_rdata == `PHCR_CTRL_SIZE_PAT;
    endproperty
    a_ctrl_sizing: assert property (p_ctrl_sizing)
        else $error("Controller base sizing pattern wrong.");

    property p_ctrl_reset;
        @(posedge clk) !rstn |=> controller_base_addr == `PHCR_ZERO_WORD && vendor_ext_base_addr == `PHCR_ZERO_WORD;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset)
        else $error("Base address registers not zero after reset.");

    property p_ctrl_low_zero;
        @(posedge clk) disable iff (!rstn)
            (cfg_rvalid && st_reg.rd_sel == PHCR_SEL_CTRL) |-> cfg_rdata[`PHCR_CTRL_LSB-1:0] == '0;
    endproperty
    a_ctrl_low_zero: assert property (p_ctrl_low_zero)
        else $error("Controller base low bits read non-zero.");

    property p_ctrl_type;
        @(posedge clk) disable iff (!rstn) controller_base_addr[3:0] == 4'h0;
    endproperty
    a_ctrl_type: assert property (p_ctrl_type)
        else $error("Controller base type bits non-zero.");

    property p_vext_sizing;
        @(posedge clk) disable iff (!rstn)
            s_vext_fill ##1 s_read_of(PHCR_SEL_VEXT) |=> cfg_rvalid && cfg_rdata == `PHCR_VEXT_SIZE_PAT;
    endproperty
    a_vext_sizing: assert property (p_vext_sizing)
        else $error("Vendor-extension base sizing pattern wrong.");

    property p_vext_store;
        @(posedge clk) disable iff (!rstn)
            s_vext_fill |=> vendor_ext_base_addr[`PHCR_DATA_W-1:`PHCR_VEXT_LSB] == {`PHCR_VEXT_W{1'b1}};
    endproperty
    a_vext_store: assert property (p_vext_store)
        else $error("Vendor-extension base upper bits not stored.");

    property p_vext_low_zero;
        @(posedge clk) disable iff (!rstn)
            (cfg_rvalid && st_reg.rd_sel == PHCR_SEL_VEXT) |-> cfg_rdata[`PHCR_VEXT_LSB-1:0] == '0;
    endproperty
    a_vext_low_zero: assert property (p_vext_low_zero)
        else $error("Vendor-extension base low bits read non-zero.");

    property p_card_zero;
        @(posedge clk) disable iff (!rstn)
            s_read_of(PHCR_SEL_CARD) |=> cfg_rvalid && cfg_rdata == `PHCR_ZERO_WORD;
    endproperty
    a_card_zero: assert property (p_card_zero)
        else $error("Card-information register read non-zero.");

    property p_subsys_no_cfg_write;
        @(posedge clk) disable iff (!rstn)
            (cfg_wr && wr_sel == PHCR_SEL_SUBSYS && !eeprom_id_load && !subsys_access_wr && !st_reg.function_reset_in_sync)
                |=> $stable(subsys_identity);
    endproperty
    a_subsys_no_cfg_write: assert property (p_subsys_no_cfg_write)
        else $error("Configuration write altered subsystem identity.");

    property p_subsys_layout;
        @(posedge clk) disable iff (!rstn)
            (cfg_rd && rd_sel_now == PHCR_SEL_SUBSYS) |=>
                cfg_rdata[`PHCR_DATA_W-1:`PHCR_SSDEV_LSB] == $past(subsys_identity[`PHCR_DATA_W-1:`PHCR_SSDEV_LSB])
                && cfg_rdata[`PHCR_ID_W-1:`PHCR_SSVEN_LSB] == $past(subsys_identity[`PHCR_ID_W-1:`PHCR_SSVEN_LSB]);
    endproperty
    a_subsys_layout: assert property (p_subsys_layout)
        else $error("Subsystem identity fields misplaced on read.");

    property p_function_reset_in_clears;
        @(posedge clk) disable iff (!rstn)
            function_reset_in [*3] |=> subsys_identity == `PHCR_SUBSYS_RST;
    endproperty
    a_function_reset_in_clears: assert property (p_function_reset_in_clears)
        else $error("Function reset did not clear subsystem identity within three cycles.");

    property p_cap_ptr;
        @(posedge clk) disable iff (!rstn)
            s_read_of(PHCR_SEL_CAPP) |=> cfg_rdata == {24'h00_0000, `PHCR_OFS_PM_CAP};
    endproperty
    a_cap_ptr: assert property (p_cap_ptr)
        else $error("Capability pointer did not read 44h.");

    property p_ro_write;
        @(posedge clk) disable iff (!rstn)
            (cfg_wr && wr_sel != PHCR_SEL_CTRL && wr_sel != PHCR_SEL_VEXT) |=>
                $stable(controller_base_addr) && $stable(vendor_ext_base_addr);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("Write to a read-only register changed a base address.");

    property p_rvalid_timing;
        @(posedge clk) disable iff (!rstn) cfg_rd |=> cfg_rvalid;
    endproperty
    a_rvalid_timing: assert property (p_rvalid_timing)
        else $error("Read answer did not follow one cycle after the request.");

endmodule // phcr_header_regs

// ---- verif/phcr_host_model.sv ----
// Host configuration software model that issues configuration reads and writes.
`timescale 1ns/1ps

module phcr_host_model (
    // Clock
    input wire logic clk,
    // Configuration access
    output phcr_pkg::phcr_addr_t cfg_addr,
    output logic cfg_rd,
    output logic cfg_wr,
    output phcr_pkg::phcr_be_t cfg_be,
    output phcr_pkg::phcr_word_t cfg_wdata,
    input wire phcr_pkg::phcr_word_t cfg_rdata,
    input wire logic cfg_rvalid
);
    import phcr_pkg::*;

    initial begin
        cfg_addr = 8'h00;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // ------------------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------------------
    // Address and data are inverted once released, so a stale value is never mistaken for a live one.
    task automatic wr(input phcr_addr_t a, input phcr_be_t b, input phcr_word_t d);
        @(posedge clk);
        cfg_addr <= a;
        cfg_be <= b;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask

    task automatic rd(input phcr_addr_t a, output phcr_word_t d, output logic ok);
        @(posedge clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        rd_tail(a, d, ok);
    endtask

    // Sizing write followed at once by its read-back, as configuration software does it.
    task automatic wr_rd(input phcr_addr_t a, input phcr_word_t wd, output phcr_word_t d, output logic ok);
        @(posedge clk);
        cfg_addr <= a;
        cfg_be <= 4'hF;
        cfg_wdata <= wd;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b1;
        cfg_wdata <= ~wd;
        rd_tail(a, d, ok);
    endtask

    // Holds the read request over the edge that takes it, then waits a bounded time for the answer.
    task automatic rd_tail(input phcr_addr_t a, output phcr_word_t d, output logic ok);
        int i;
        @(posedge clk);
        cfg_rd <= 1'b0;
        cfg_addr <= ~a;
        ok = 1'b0;
        d = 32'h0000_0000;
        for (i = 0; i < 4 && !ok; i++) begin
            #1;
            if (cfg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = cfg_rdata;
            end else begin
                @(posedge clk);
            end
        end
    endtask
endmodule // phcr_host_model

// ---- verif/testbench.sv ----
// Self-checking testbench for the configuration header register bank.
`timescale 1ns/1ps

module testbench;
    import phcr_pkg::*;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    phcr_addr_t cfg_addr;
    logic cfg_rd, cfg_wr, cfg_rvalid;
    phcr_be_t cfg_be;
    phcr_word_t cfg_wdata, cfg_rdata, ctrl_base, vext_base, ident;
    logic ee_load = 1'b0;
    logic acc_wr = 1'b0;
    logic func_rst = 1'b0;
    phcr_word_t ee_data = 32'h0000_0000;
    phcr_word_t acc_data = 32'h0000_0000;
    int n_mismatch = 0;
    int tests_run = 0;
    phcr_addr_t map_a [8] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h28, 8'h2C, 8'h34, 8'h30};
    phcr_word_t map_e [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0044, 32'h0};

    always #2.5 clk = ~clk;

    phcr_host_model host (.clk(clk), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    phcr_header_regs dut (.clk(clk), .rstn(rstn), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .eeprom_id_load(ee_load), .eeprom_id_data(ee_data), .subsys_access_wr(acc_wr),
        .subsys_access_data(acc_data), .function_reset_in(func_rst), .controller_base_addr(ctrl_base),
        .vendor_ext_base_addr(vext_base), .subsys_identity(ident));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input phcr_word_t seen, input phcr_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rdchk(input phcr_addr_t a, input phcr_word_t exp, input logic fill = 1'b0);
        phcr_word_t d;
        logic ok;
        if (fill) host.wr_rd(a, 32'hFFFF_FFFF, d, ok);
        else host.rd(a, d, ok);
        if (!ok) begin
            n_mismatch++;
            $display("BAD read answer at %h never came", a);
            conclude();
        end else begin
            check($sformatf("read %h", a), d, exp);
        end
    endtask

    // Identity strobes are taken at the next edge; the result is looked at once that edge has landed.
    task automatic id_pulse(input logic ee, input phcr_word_t ed, input logic ac, input phcr_word_t ad);
        @(posedge clk);
        ee_load <= ee;
        ee_data <= ed;
        acc_wr <= ac;
        acc_data <= ad;
        @(posedge clk);
        ee_load <= 1'b0;
        acc_wr <= 1'b0;
        ee_data <= ~ed;
        acc_data <= ~ad;
        #1;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset_map();
        for (int i = 0; i < 8; i++) rdchk(map_a[i], map_e[i]);
        check("ctrl base out", ctrl_base, 32'h0000_0000);
        check("vext base out", vext_base, 32'h0000_0000);
    endtask

    task automatic t_readonly();
        for (int i = 0; i < 8; i++) if (i != 1 && i != 2) host.wr(map_a[i], 4'hF, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++) if (i != 1 && i != 2) rdchk(map_a[i], map_e[i]);
    endtask

    task automatic t_sizing();
        rdchk(8'h10, 32'hFFFF_F800, 1'b1);
        rdchk(8'h14, 32'hFFFF_C000, 1'b1);
        check("ctrl base out", ctrl_base, 32'hFFFF_F800);
        host.wr(8'h10, 4'h8, 32'h1234_5678);
        host.wr(8'h14, 4'h3, 32'h0000_3FFF);
        rdchk(8'h10, 32'h12FF_F800);
        rdchk(8'h14, 32'hFFFF_0000);
        check("vext base out", vext_base, 32'hFFFF_0000);
    endtask

    task automatic t_identity();
        id_pulse(1'b1, 32'hBEEF_1234, 1'b0, 32'h0);
        check("identity eeprom", ident, 32'hBEEF_1234);
        rdchk(8'h2C, 32'hBEEF_1234);
        id_pulse(1'b1, 32'h1111_2222, 1'b1, 32'h3333_4444);
        check("identity access", ident, 32'h3333_4444);
        host.wr(8'h2C, 4'hF, 32'h0000_0000);
        rdchk(8'h2C, 32'h3333_4444);
        @(posedge clk);
        func_rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("identity func reset", ident, 32'h0000_0000);
        check("ctrl kept", ctrl_base, 32'h12FF_F800);
        id_pulse(1'b1, 32'h5555_6666, 1'b0, 32'h0);
        check("load in func reset", ident, 32'h0000_0000);
        @(posedge clk);
        func_rst <= 1'b0;
        repeat (3) @(posedge clk);
        id_pulse(1'b0, 32'h0, 1'b1, 32'h7777_8888);
        check("identity reload", ident, 32'h7777_8888);
    endtask

    task automatic t_fund_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("identity fund reset", ident, 32'h0000_0000);
        check("ctrl fund reset", ctrl_base, 32'h0000_0000);
        check("vext fund reset", vext_base, 32'h0000_0000);
        @(posedge clk);
        rstn <= 1'b1;
        rdchk(8'h10, 32'h0000_0000);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_reset_map();
        t_readonly();
        t_sizing();
        t_identity();
        t_fund_reset();
        conclude();
    end
endmodule // testbench
